// ---- design/smcr_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.vh"
module smcr_regs (
  input wire clk, // 40 MHz clock
  input wire reset, // Async reset, active high
  input wire wr_en, // Register write strobe
  input wire rd_en, // Register read strobe
  input wire [7:0] addr, // Register address
  input wire [7:0] wdata, // Write data
  output reg [7:0] rdata, // Read data
  input wire transmit_disable_input, // Transmit disable pin
  input wire lo_clock_in, // Raw LO clock enable
  output wire lo_clock_run, // Gated LO clock enable
  output reg [4:0] cp_current_code, // Active charge pump code
  output reg ref_halve_en, // Halving divider selected
  output reg ref_double_en, // Doubler enabled
  output reg [5:0] ref_div_ratio, // Division ratio 1..32
  output reg pll_power_down, // PLL powered down
  output reg lock_detect_en, // Lock detector on
  output reg [1:0] lock_count_sel, // Lock count setting
  output reg lock_fine, // Fine lock window
  output reg autocal_en, // Autocalibration enabled
  output reg [7:0] autocal_time, // Autocal timer value
  output reg lo_monitor_on, // Monitor output on
  output reg [1:0] lo_monitor_level, // Monitor power code
  output reg vco_range, // VCO range select
  output reg rf_divider_pd, // RF divider off
  output reg [2:0] rf_output_div_select, // Active RF divide code
  output reg modulator_on, // Modulator powered
  output reg [5:0] atten_db, // Attenuation in dB
  output reg atten_switch_open, // Attenuator switch open
  output reg acquire_start // New acquisition pulse
);
  reg [7:0] reg_pll;
  reg [7:0] reg_ldb;
  reg [7:0] reg_txd;
  reg [7:0] reg_lda;
  reg [7:0] reg_acal;
  reg [7:0] reg_atim;
  reg [7:0] reg_lomon;
  reg [7:0] reg_div_hi;
  reg [7:0] reg_mod;
  reg [7:0] reg_att;
  reg commit_q;
  wire commit;
  wire [7:0] cp_shadow;
  wire [7:0] cp_active;
  wire [7:0] ref_shadow;
  wire [7:0] ref_active;
  wire [7:0] div_shadow;
  wire [7:0] div_active;
  wire load_cp;
  wire load_ref;
  wire load_div;
  wire wr_pll;
  wire wr_ldb;
  wire wr_txd;
  wire wr_lda;
  wire wr_acal;
  wire wr_atim;
  wire wr_lomon;
  wire wr_div;
  wire wr_mod;
  wire wr_att;
  reg [7:0] next_rdata;

  // Unlisted codes clamp to 31 dB; callers must not rely on it
  function [5:0] att_decode;
    input [5:0] code;
    begin
      if (!code[5])
        att_decode = {1'b0, code[4:0]};
      else if (code[4])
        att_decode = 6'h20 + {2'b00, code[3:0]};
      else
        att_decode = 6'h1f;
    end
  endfunction

  function [5:0] ref_decode;
    input [4:0] code;
    begin
      if (code == 5'h00)
        ref_decode = 6'h20;
      else
        ref_decode = {1'b0, code};
    end
  endfunction

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  assign commit = wr_en && wr_hit(addr, `SMCR_A_COMMIT);
  assign load_cp = wr_en && wr_hit(addr, `SMCR_A_CP);
  assign load_ref = wr_en && wr_hit(addr, `SMCR_A_REF);
  assign load_div = wr_en && wr_hit(addr, `SMCR_A_DIV);
  assign wr_pll = wr_en && wr_hit(addr, `SMCR_A_PLL);
  assign wr_ldb = wr_en && wr_hit(addr, `SMCR_A_LDB);
  assign wr_txd = wr_en && wr_hit(addr, `SMCR_A_TXD);
  assign wr_lda = wr_en && wr_hit(addr, `SMCR_A_LDA);
  assign wr_acal = wr_en && wr_hit(addr, `SMCR_A_ACAL);
  assign wr_atim = wr_en && wr_hit(addr, `SMCR_A_ATIM);
  assign wr_lomon = wr_en && wr_hit(addr, `SMCR_A_LOMON);
  assign wr_div = wr_en && wr_hit(addr, `SMCR_A_DIV);
  assign wr_mod = wr_en && wr_hit(addr, `SMCR_A_MOD);
  assign wr_att = wr_en && wr_hit(addr, `SMCR_A_ATT);

  smcr_shadow u_cp (
    .clk(clk),
    .reset(reset),
    .load(load_cp),
    .commit(commit),
    .wdata(wdata),
    .shadow(cp_shadow),
    .active(cp_active)
  );

  smcr_shadow u_ref (
    .clk(clk),
    .reset(reset),
    .load(load_ref),
    .commit(commit),
    .wdata(wdata),
    .shadow(ref_shadow),
    .active(ref_active)
  );

  // Only the divide-select field is double-buffered
  smcr_shadow u_div (
    .clk(clk),
    .reset(reset),
    .load(load_div),
    .commit(commit),
    .wdata(wdata),
    .shadow(div_shadow),
    .active(div_active)
  );

  // Revision and unmapped addresses have no write decode at all
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      commit_q <= `SMCR_RST_OFF;
    end else begin
      commit_q <= commit;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_pll <= `SMCR_RST_ZERO;
    end else if (wr_pll) begin
      reg_pll <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_ldb <= `SMCR_RST_ZERO;
    end else if (wr_ldb) begin
      reg_ldb <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_txd <= `SMCR_RST_ZERO;
    end else if (wr_txd) begin
      reg_txd <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_lda <= `SMCR_RST_ZERO;
    end else if (wr_lda) begin
      reg_lda <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_acal <= `SMCR_RST_ZERO;
    end else if (wr_acal) begin
      reg_acal <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_atim <= `SMCR_RST_ZERO;
    end else if (wr_atim) begin
      reg_atim <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_lomon <= `SMCR_RST_ZERO;
    end else if (wr_lomon) begin
      reg_lomon <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_div_hi <= `SMCR_RST_ZERO;
    end else if (wr_div) begin
      reg_div_hi <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_mod <= `SMCR_RST_ZERO;
    end else if (wr_mod) begin
      reg_mod <= wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_att <= `SMCR_RST_ZERO;
    end else if (wr_att) begin
      reg_att <= wdata;
    end
  end

  // Decoded settings registered so downstream sees clean levels
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cp_current_code <= `SMCR_RST_CP;
      ref_halve_en <= `SMCR_RST_OFF;
      ref_double_en <= `SMCR_RST_OFF;
      ref_div_ratio <= `SMCR_RST_RATIO;
    end else begin
      cp_current_code <= {1'b0, cp_active[`SMCR_F_CP_HI:`SMCR_F_CP_LO]};
      ref_halve_en <= ref_active[`SMCR_B_HALVE];
      ref_double_en <= ref_active[`SMCR_B_DOUBLE];
      ref_div_ratio <= ref_decode(ref_active[`SMCR_F_RDIV_HI:0]);
    end
  end

  // PLL power and lock detector act on plain registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pll_power_down <= `SMCR_RST_OFF;
      lock_detect_en <= `SMCR_RST_OFF;
      lock_count_sel <= `SMCR_RST_LDCNT;
      lock_fine <= `SMCR_RST_OFF;
    end else begin
      pll_power_down <= reg_pll[`SMCR_B_PLLPD];
      lock_detect_en <= reg_lda[`SMCR_B_LDEN];
      lock_count_sel <= {reg_ldb[`SMCR_B_LDCNT_HI], reg_lda[`SMCR_B_LDCNT_LO]};
      lock_fine <= reg_lda[`SMCR_B_LDFINE];
    end
  end

  // Autocalibration runs unless software disables it
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      autocal_en <= `SMCR_RST_ON;
      autocal_time <= `SMCR_RST_ZERO;
    end else begin
      autocal_en <= ~reg_acal[`SMCR_B_ACALDIS];
      autocal_time <= reg_atim;
    end
  end

  // Range bit is only stored; software picks it per LO band
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lo_monitor_on <= `SMCR_RST_OFF;
      lo_monitor_level <= `SMCR_RST_MONLVL;
      vco_range <= `SMCR_RST_OFF;
    end else begin
      lo_monitor_on <= reg_lomon[`SMCR_B_MONPU];
      lo_monitor_level <= reg_lomon[`SMCR_F_MONLVL_HI:0];
      vco_range <= reg_lomon[`SMCR_B_VCORNG];
    end
  end

  // Divider power acts at once, divide code only after commit
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rf_divider_pd <= `SMCR_RST_OFF;
      rf_output_div_select <= `SMCR_RST_RF_OUTPUT_DIV_SELECT;
      modulator_on <= `SMCR_RST_OFF;
    end else begin
      rf_divider_pd <= reg_div_hi[`SMCR_B_DIVPD];
      rf_output_div_select <= div_active[`SMCR_F_RF_OUTPUT_DIV_SELECT_HI:0];
      modulator_on <= reg_mod[`SMCR_B_MODPU];
    end
  end

  // Attenuation in whole dB, switch state passed straight on
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      atten_db <= `SMCR_RST_ATT;
      atten_switch_open <= `SMCR_RST_OFF;
    end else begin
      atten_db <= att_decode(reg_att[`SMCR_F_ATT_HI:0]);
      atten_switch_open <= reg_att[`SMCR_B_SWOPEN];
    end
  end

  // Pulse trails the commit so the active copies have settled
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acquire_start <= `SMCR_RST_OFF;
    end else begin
      acquire_start <= commit_q;
    end
  end

  // Pin is combinational so the gate follows without delay
  assign lo_clock_run = lo_clock_in & ~(reg_txd[`SMCR_B_LOGATE] & transmit_disable_input);

  // Reads show staged shadow values, as software wrote them
  always @* begin
    next_rdata = rdata;
    if (rd_en) begin
      case (addr)
        `SMCR_A_CP: next_rdata = cp_shadow;
        `SMCR_A_REF: next_rdata = ref_shadow;
        `SMCR_A_PLL: next_rdata = reg_pll;
        `SMCR_A_LDB: next_rdata = reg_ldb;
        `SMCR_A_TXD: next_rdata = reg_txd;
        `SMCR_A_LDA: next_rdata = reg_lda;
        `SMCR_A_ACAL: next_rdata = reg_acal;
        `SMCR_A_ATIM: next_rdata = reg_atim;
        `SMCR_A_LOMON: next_rdata = reg_lomon;
        `SMCR_A_DIV: next_rdata = {reg_div_hi[7:3], div_shadow[2:0]};
        `SMCR_A_MOD: next_rdata = reg_mod;
        `SMCR_A_ATT: next_rdata = reg_att;
        `SMCR_A_REV: next_rdata = `SMCR_REVISION;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= `SMCR_RST_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- design/smcr_consts.vh ----
`ifndef SMCR_CONSTS_VH
`define SMCR_CONSTS_VH
`define SMCR_A_COMMIT 8'h00
`define SMCR_A_CP 8'h09
`define SMCR_A_REF 8'h0a
`define SMCR_A_PLL 8'h0c
`define SMCR_A_LDB 8'h0d
`define SMCR_A_TXD 8'h0e
`define SMCR_A_LDA 8'h17
`define SMCR_A_ACAL 8'h18
`define SMCR_A_ATIM 8'h19
`define SMCR_A_LOMON 8'h1b
`define SMCR_A_DIV 8'h1c
`define SMCR_A_MOD 8'h1d
`define SMCR_A_ATT 8'h1e
`define SMCR_A_REV 8'h21
`define SMCR_RST_ZERO 8'h00
`define SMCR_REVISION 8'h01
`define SMCR_B_HALVE 6
`define SMCR_B_DOUBLE 5
`define SMCR_B_PLLPD 2
`define SMCR_B_LDCNT_HI 6
`define SMCR_B_LOGATE 7
`define SMCR_B_LDEN 4
`define SMCR_B_LDCNT_LO 3
`define SMCR_B_LDFINE 2
`define SMCR_B_ACALDIS 0
`define SMCR_B_VCORNG 4
`define SMCR_B_MONPU 2
`define SMCR_B_DIVPD 4
`define SMCR_B_MODPU 0
`define SMCR_B_SWOPEN 6
`define SMCR_RST_OFF 1'h0
`define SMCR_RST_ON 1'h1
`define SMCR_RST_CP 5'h00
`define SMCR_RST_RATIO 6'h20
`define SMCR_RST_LDCNT 2'h0
`define SMCR_RST_MONLVL 2'h0
`define SMCR_RST_RF_OUTPUT_DIV_SELECT 3'h0
`define SMCR_RST_ATT 6'h00
`define SMCR_F_CP_HI 7
`define SMCR_F_CP_LO 4
`define SMCR_F_RDIV_HI 4
`define SMCR_F_MONLVL_HI 1
`define SMCR_F_RF_OUTPUT_DIV_SELECT_HI 2
`define SMCR_F_ATT_HI 5
`endif

// ---- design/smcr_shadow.v ----
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.vh"
module smcr_shadow (
  input wire clk, // System clock
  input wire reset, // Async reset
  input wire load, // Shadow write strobe
  input wire commit, // Commit pulse
  input wire [7:0] wdata, // Write data
  output reg [7:0] shadow, // Staged value
  output reg [7:0] active // Applied value
);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow <= `SMCR_RST_ZERO;
      active <= `SMCR_RST_ZERO;
    end else begin
      if (load)
        shadow <= wdata;
      if (commit)
        active <= shadow;
    end
  end
endmodule
`default_nettype wire

// ---- sim/smcr_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.vh"
module smcr_regs_chk (
  input wire logic clk, // Clock
  input wire logic reset, // Async reset
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [7:0] addr, // Address
  input wire logic [7:0] rdata, // Read data
  input wire logic transmit_disable_input, // Tx disable pin
  input wire logic lo_clock_in, // Raw LO enable
  input wire logic lo_clock_run, // Gated LO enable
  input wire logic [4:0] cp_current_code, // Pump code
  input wire logic [5:0] ref_div_ratio, // Ref ratio
  input wire logic ref_halve_en, // Halver
  input wire logic ref_double_en, // Doubler
  input wire logic [2:0] rf_output_div_select, // RF divide
  input wire logic acquire_start // Acquisition pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence commit_wr;
    wr_en && addr == 8'h00;
  endsequence
  sequence commit_seen;
    $past(wr_en && addr == 8'h00, 2);
  endsequence
  chk_acq_after: assert property (commit_wr |-> ##2 acquire_start)
    else $error("no acquisition pulse after commit");
  chk_acq_cause: assert property (acquire_start |-> commit_seen)
    else $error("acquisition pulse without commit");
  chk_cp_commit: assert property ($changed(cp_current_code) |-> commit_seen)
    else $error("pump code moved without commit");
  chk_div_commit: assert property ($changed({rf_output_div_select, ref_div_ratio, ref_halve_en, ref_double_en})
    |-> commit_seen) else $error("buffered field moved without commit");
  chk_ratio_range: assert property (ref_div_ratio >= 6'h01 && ref_div_ratio <= 6'h20)
    else $error("reference ratio out of range");
  chk_cp_nibble: assert property (cp_current_code[4] == 1'b0)
    else $error("pump code above sixteen steps");
  chk_rev_read: assert property (rd_en && addr == 8'h21 |=> rdata == `SMCR_REVISION)
    else $error("revision code changed");
  chk_lo_free: assert property (!transmit_disable_input |-> lo_clock_run == lo_clock_in)
    else $error("LO clock stopped without tx disable");
endmodule
bind smcr_regs smcr_regs_chk u_chk (.clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
  .rdata(rdata), .transmit_disable_input(transmit_disable_input), .lo_clock_in(lo_clock_in),
  .lo_clock_run(lo_clock_run), .cp_current_code(cp_current_code), .ref_div_ratio(ref_div_ratio),
  .ref_halve_en(ref_halve_en), .ref_double_en(ref_double_en), .rf_output_div_select(rf_output_div_select),
  .acquire_start(acquire_start));
`default_nettype wire

// ---- sim/smcr_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.vh"
module smcr_regs_test;
  logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, txd = 0, lci = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, a09, a0a;
  logic [2:0] a1c;
  logic [7:0] m [0:255];
  logic [7:0] tbl [0:14] = '{8'h00, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h17, 8'h18, 8'h19, 8'h1b, 8'h1c,
    8'h1d, 8'h1e, 8'h21, 8'h40};
  wire [7:0] rdata;
  wire [42:0] got;
  wire lo_clock_run, acquire_start;
  int err_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  smcr_regs u_dut (.clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .transmit_disable_input(txd), .lo_clock_in(lci), .lo_clock_run(lo_clock_run),
    .cp_current_code(got[42:38]), .ref_halve_en(got[37]), .ref_double_en(got[36]), .ref_div_ratio(got[35:30]),
    .pll_power_down(got[29]), .lock_detect_en(got[28]), .lock_count_sel(got[27:26]), .lock_fine(got[25]),
    .autocal_en(got[24]), .autocal_time(got[23:16]), .lo_monitor_on(got[15]), .lo_monitor_level(got[14:13]),
    .vco_range(got[12]), .rf_divider_pd(got[11]), .rf_output_div_select(got[10:8]), .modulator_on(got[7]),
    .atten_db(got[6:1]), .atten_switch_open(got[0]), .acquire_start(acquire_start));
  function automatic logic [42:0] expv();
    logic [5:0] at;
    at = m[8'h1e][5:0];
    return {1'b0, a09[7:4], a0a[6], a0a[5], (a0a[4:0] == 5'h00) ? 6'h20 : {1'b0, a0a[4:0]}, m[8'h0c][2],
      m[8'h17][4], m[8'h0d][6], m[8'h17][3], m[8'h17][2], ~m[8'h18][0], m[8'h19], m[8'h1b][2], m[8'h1b][1:0],
      m[8'h1b][4], m[8'h1c][4], a1c, m[8'h1d][0], at[5] ? at - 6'h10 : at, m[8'h1e][6]};
  endfunction
  task test_done();
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [42:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task do_reset();
    @(posedge clk) reset <= 1;
    foreach (m[i]) m[i] = 8'h00;
    m[8'h21] = `SMCR_REVISION;
    {a09, a0a, a1c} = '0;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk) #1 chk(got, expv());
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk) wr_en <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr_en <= 0;
    if (a == 8'h00) {a09, a0a, a1c} = {m[8'h09], m[8'h0a], m[8'h1c][2:0]};
    else if (a != 8'h21 && a != 8'h40) m[a] = d;
    @(posedge clk);
    #1 chk(acquire_start, a == 8'h00);
    @(posedge clk) #1 chk(got, expv());
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk) rd_en <= 1;
    addr <= a;
    @(posedge clk) rd_en <= 0;
    #1 chk(rdata, m[a]);
  endtask
  task gate();
    repeat (16) begin
      @(posedge clk) txd <= 1'($urandom);
      lci <= 1'($urandom);
      #1 chk(lo_clock_run, lci & ~(m[8'h0e][7] & txd));
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    logic [7:0] a, d;
    void'($urandom(30434));
    do_reset();
    for (int i = 0; i < 60; i++) begin
      a = tbl[$urandom % 15];
      d = 8'($urandom);
      if (a == 8'h1e && d[5:4] == 2'b10) d[5:4] = 2'b11;
      wr(a, d);
      if (i % 12 == 11) for (int j = 0; j < 15; j++) rd(tbl[j]);
    end
    for (int k = 0; k < 32; k++) begin
      wr(8'h09, {k[3:0], 4'h0});
      wr(8'h0a, {1'b0, k[4:3], k[4:0]});
      wr(8'h00, 8'h00);
    end
    for (int k = 0; k < 48; k++) wr(8'h1e, (k < 32) ? k[7:0] : k[7:0] + 8'h10);
    wr(8'h0e, 8'h80);
    gate();
    wr(8'h0e, 8'h00);
    gate();
    do_reset();
    for (int j = 0; j < 15; j++) rd(tbl[j]);
    test_done();
  end
endmodule
`default_nettype wire
